// ### logic/usc_pkg.sv
package usc_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef logic [1:0] usc_addr_t;
  typedef logic [7:0] usc_byte_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} usc_tx_state_t;
  typedef enum logic {RX_IDLE, RX_FRAME} usc_rx_state_t;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_TIME_NS   = 8680;
  localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 11;
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] SAMPLE_1 = CNT_W'(BIT_CYCLES * 7 / 16);
  localparam logic [CNT_W-1:0] SAMPLE_2 = CNT_W'(BIT_CYCLES * 8 / 16);
  localparam logic [CNT_W-1:0] SAMPLE_3 = CNT_W'(BIT_CYCLES * 9 / 16);
  localparam logic [3:0]       FRAME_LEN_SHORT = 4'hA;
  localparam logic [3:0]       FRAME_LEN_LONG  = 4'hB;

  // ****************************************
  // register map
  // ****************************************
  localparam usc_addr_t ADDR_STATUS = 2'h0;
  localparam usc_addr_t ADDR_DATA   = 2'h1;
  localparam usc_addr_t ADDR_CTRL2  = 2'h2;
  localparam usc_addr_t ADDR_CTRL1  = 2'h3;

  // status bits
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;
  localparam int ST_PARITY   = 0;

  // control one bits
  localparam int CR1_RX9  = 7;
  localparam int CR1_TX9  = 6;
  localparam int CR1_PDN  = 5;
  localparam int CR1_LONG = 4;
  localparam int CR1_WAKE = 3;
  localparam int CR1_PCE  = 2;
  localparam int CR1_PS   = 1;
  localparam int CR1_PIE  = 0;

  // control two bits
  localparam int CR2_TIE  = 7;
  localparam int CR2_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int CR2_RIE  = 5;
  localparam int CR2_IDLE_IRQ_ENABLE = 4;
  localparam int CR2_TE   = 3;
  localparam int CR2_RE   = 2;

  // reset values and clear masks
  localparam usc_byte_t STATUS_RESET  = 8'hC0;
  localparam usc_byte_t CTRL1_RESET   = 8'h00;
  localparam usc_byte_t CTRL2_RESET   = 8'h00;
  localparam usc_byte_t CLR_ON_WRITE  = 8'hC1;
  localparam usc_byte_t CLR_ON_READ   = 8'h3F;
  localparam usc_byte_t BYTE_ZERO     = 8'h00;

endpackage : usc_pkg

// ### logic/usc_sync_if.sv
`timescale 1ns/100ps

// ****************************************
// raw pin in, filtered level out
// ****************************************
interface usc_sync_if;
  logic raw;
  logic level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : usc_sync_if

// ### logic/usc_sync.sv
`timescale 1ns/100ps

module usc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin path
  usc_sync_if.sync port
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  // three flops; level follows once second and third agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
      level  <= 1'b1;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

  assign port.level = level;

endmodule : usc_sync

// ### logic/usc_top.sv
`timescale 1ns/100ps

// Overview of operation
// - In wait mode the interface runs normally; enabled interrupts request wake.
// - In halt mode registers freeze and transfers stop until halt ends.
// - All events share one request, each gated by enable and CPU mask.
// - Receive-full wakes from wait, never from halt.
// - Status bit 7 sets on holding-to-shifter move; cleared by status then data write.
// - Status bit 6 sets when a data character ends; cleared like bit 7.
// - Status bit 5 sets when received data is readable; status then data read clears.
// - Status bit 4 sets on idle line; rearmed only after receive-full sets.
// - Status bit 3 sets on new word while full; held data kept.
// - Status bit 2 flags noise on a character, no interrupt of its own.
// - Status bit 1 flags framing errors; overrun hides framing on same word.
// - Status bit 0 flags parity error with parity on; status read then data access.
// - Status register is read-only and resets to C0h.
// - With nine-bit words the ninth bit is captured and sent from control one.
// - Power-down stops prescaler and outputs after the current byte.
// - Word length bit selects eight or nine data bits, one start, one stop.
// - Wake bit picks idle or address mark; in LIN mode header detect method.
// - Parity enable gives generation and checking for bytes, checking only for LIN.
// - Parity select: 0 even, 1 odd; takes effect after current byte.
// - Parity interrupt enable gates byte or LIN parity errors per LIN select.
// - With parity on, parity replaces the most significant data bit sent.
// - A break is a framing error and loads 00h into receive data.
// - Control two bits 7..4 are the tx empty, tx done, rx and idle enables.
module usc_top (
  // clock and reset
  input  wire  logic              CLK,
  input  wire  logic              RST,
  // register port
  input  wire  usc_pkg::usc_addr_t ADDR,
  input  wire  usc_pkg::usc_byte_t WDATA,
  input  wire  logic              WR,
  input  wire  logic              RD,
  output var   usc_pkg::usc_byte_t RDATA,
  // serial pins
  input  wire  logic              RXD,
  output logic                    TXD,
  // power and cpu
  input  wire  logic              HALT_MODE,
  input  wire  logic              WAIT_MODE,
  input  wire  logic              CPU_INT_MASK,
  // lin hooks
  input  wire  logic              LIN_ENABLE,
  input  wire  logic              LIN_PARITY_SELECT,
  input  wire  logic              LIN_PARITY_ERROR,
  input  wire  logic              LIN_HEADER_FLAG,
  input  wire  logic              LIN_SYNC_ERROR_FLAG,
  input  wire  logic              LIN_HEADER_IRQ_ENABLE,
  // requests and modes
  output logic                    IRQ,
  output logic                    WAKE_REQ,
  output logic                    PRESCALER_RUN,
  output logic                    WAKE_ADDRESS_MARK,
  output logic                    LIN_HEADER_DETECT_METHOD
);

  import usc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  usc_byte_t        status;
  usc_byte_t        armed;
  usc_byte_t        ctrl1;
  usc_byte_t        ctrl2;
  usc_byte_t        set_vec;
  usc_byte_t        clr_vec;
  usc_byte_t        next_status;
  usc_byte_t        rd_mux;
  usc_byte_t        transmit_holding_register;
  usc_byte_t        receive_holding_register;
  logic             tdr_pending;
  usc_tx_state_t    tx_state;
  logic [CNT_W-1:0] tx_cnt;
  logic [3:0]       tx_bit;
  logic [3:0]       tx_len;
  logic [10:0]      tx_shift;
  usc_rx_state_t    rx_state;
  logic [CNT_W-1:0] rx_cnt;
  logic [3:0]       rx_bit;
  logic [3:0]       rx_len;
  logic [3:0]       idle_bits;
  logic             idle_armed;
  logic [1:0]       rx_samp;
  logic [8:0]       rx_shift;
  logic             rx_noise;
  logic             rx_long;
  logic             rx_ps;
  logic             rx_level;

  // ****************************************
  // pin synchroniser
  // ****************************************
  usc_sync_if rx_if ();
  assign rx_if.raw = RXD;

  usc_sync u_sync (
    .clk  (CLK),
    .rst  (RST),
    .port (rx_if.sync)
  );
  assign rx_level = rx_if.level;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic [3:0] dec_addr(input usc_addr_t a);
    logic [3:0] hit;
    hit = 4'h0;
    if (a == ADDR_STATUS) begin
      hit = 4'h1;
    end else if (a == ADDR_DATA) begin
      hit = 4'h2;
    end else if (a == ADDR_CTRL2) begin
      hit = 4'h4;
    end else if (a == ADDR_CTRL1) begin
      hit = 4'h8;
    end
    return hit;
  endfunction : dec_addr

  wire       run       = ~HALT_MODE;
  wire [3:0] hit       = dec_addr(ADDR);
  wire       rd_status = RD & run & hit[0];
  wire       rd_data   = RD & run & hit[1];
  wire       wr_data   = WR & run & hit[1];
  wire       wr_ctrl2  = WR & run & hit[2];
  wire       wr_ctrl1  = WR & run & hit[3];

  // control field views
  wire       long_word = ctrl1[CR1_LONG];
  wire       parity_control_enable       = ctrl1[CR1_PCE];
  wire       pdn       = ctrl1[CR1_PDN];
  wire       tx_en     = ctrl2[CR2_TE] & ~pdn;
  wire       rx_en     = ctrl2[CR2_RE] & ~pdn;
  // parity generation only for byte parity
  wire       par_gen   = parity_control_enable & ~LIN_PARITY_SELECT;

  // ****************************************
  // transmit frame build
  // ****************************************
  // ninth bit from control one
  wire [8:0]  tx_raw   = {ctrl1[CR1_TX9], transmit_holding_register};
  // parity sense sampled at frame load
  wire        par_hi   = ^transmit_holding_register ^ ctrl1[CR1_PS];
  wire        par_lo   = ^transmit_holding_register[6:0] ^ ctrl1[CR1_PS];
  wire [8:0]  tx_data  = ~par_gen ? tx_raw :
                         long_word ? {par_hi, transmit_holding_register} : {1'b0, par_lo, transmit_holding_register[6:0]};
  // frame of start, eight or nine data, stop
  wire [10:0] tx_frame = long_word ? {1'b1, tx_data, 1'b0} : {2'b11, tx_data[7:0], 1'b0};
  wire        tx_load  = run & (tx_state == TX_IDLE) & tdr_pending & tx_en;
  wire        tx_end   = run & (tx_state == TX_SHIFT) & (tx_cnt == BIT_LAST)
                         & (tx_bit == tx_len - 4'h1);

  // ****************************************
  // receive evaluation
  // ****************************************
  wire        rx_eval  = run & (rx_state == RX_FRAME) & (rx_cnt == SAMPLE_3);
  wire        maj      = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_level)
                         | (rx_samp[1] & rx_level);
  wire        nz_bit   = (rx_samp[0] != rx_samp[1]) | (rx_samp[1] != rx_level);
  wire        rx_start_bad = rx_eval & (rx_bit == 4'h0) & maj;
  wire        rx_stop  = rx_eval & (rx_bit == rx_len - 4'h1);
  wire [8:0]  rx_word  = rx_long ? rx_shift : {1'b0, rx_shift[8:1]};
  wire        rx_perr  = parity_control_enable & ~LIN_PARITY_SELECT
                         & ((rx_long ? ^rx_word : ^rx_word[7:0]) != rx_ps);
  // new word while full is an overrun
  wire        rx_over  = rx_stop & status[ST_RX_FULL];
  wire        rx_ok    = rx_stop & ~status[ST_RX_FULL];
  wire        idle_evt = run & (rx_state == RX_IDLE) & rx_en & rx_level & idle_armed
                         & (rx_cnt == BIT_LAST) & (idle_bits == rx_len - 4'h1);

  // ****************************************
  // flag set and clear vectors
  // ****************************************
  always_comb begin
    set_vec = BYTE_ZERO;
    // tx empty on transfer to shifter
    set_vec[ST_TX_EMPTY] = tx_load;
    // tx done only after a data frame
    set_vec[ST_TX_DONE]  = tx_end;
    // rx full on transfer to data reg
    set_vec[ST_RX_FULL]  = rx_ok;
    set_vec[ST_IDLE]     = idle_evt;
    set_vec[ST_OVERRUN]  = rx_over;
    // noise seen on any sample set
    set_vec[ST_NOISE]    = rx_ok & (rx_noise | nz_bit);
    set_vec[ST_FRAMING]  = rx_ok & ~maj;
    set_vec[ST_PARITY]   = (rx_ok & rx_perr) | (run & parity_control_enable & LIN_PARITY_SELECT & LIN_PARITY_ERROR);
  end

  // clear only flags armed by a status read
  assign clr_vec     = armed & ((wr_data ? CLR_ON_WRITE : BYTE_ZERO)
                              | (rd_data ? CLR_ON_READ : BYTE_ZERO)
                              | (wr_data ? BYTE_ZERO : {7'h00, rd_data}));
  // set wins over clear
  assign next_status = (status & ~clr_vec) | set_vec;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status <= STATUS_RESET;
      armed  <= BYTE_ZERO;
    end else begin
      status <= next_status;
      if (rd_status) begin
        armed <= status;
      end else if (rd_data | wr_data) begin
        armed <= armed & ~clr_vec;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl1 <= CTRL1_RESET;
      ctrl2 <= CTRL2_RESET;
    end else begin
      if (wr_ctrl1) begin
        ctrl1[6:0] <= WDATA[6:0];
      end
      if (rx_ok & rx_long) begin
        ctrl1[CR1_RX9] <= rx_word[8];
      end
      if (wr_ctrl2) begin
        ctrl2 <= WDATA;
      end
    end
  end

  // ****************************************
  // transmit holding register
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      transmit_holding_register         <= BYTE_ZERO;
      tdr_pending <= 1'b0;
    end else if (wr_data) begin
      transmit_holding_register         <= WDATA;
      tdr_pending <= 1'b1;
    end else if (tx_load) begin
      tdr_pending <= 1'b0;
    end
  end

  // ****************************************
  // transmit shifter
  // ****************************************
  // shifter frozen in halt
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_state <= TX_IDLE;
      tx_cnt   <= '0;
      tx_bit   <= 4'h0;
      tx_len   <= FRAME_LEN_SHORT;
      tx_shift <= 11'h7FF;
      TXD      <= 1'b1;
    end else if (run) begin
      case (tx_state)
        TX_IDLE: begin
          TXD <= 1'b1;
          // no new frame while powered down
          if (tx_load) begin
            tx_shift <= tx_frame;
            tx_len   <= long_word ? FRAME_LEN_LONG : FRAME_LEN_SHORT;
            tx_cnt   <= '0;
            tx_bit   <= 4'h0;
            TXD      <= tx_frame[0];
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_cnt == BIT_LAST) begin
            tx_cnt <= '0;
            if (tx_end) begin
              TXD      <= 1'b1;
              tx_state <= TX_IDLE;
            end else begin
              tx_shift <= {1'b1, tx_shift[10:1]};
              TXD      <= tx_shift[1];
              tx_bit   <= tx_bit + 4'h1;
            end
          end else begin
            tx_cnt <= tx_cnt + 1'b1;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // receive shifter and idle timer
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_state   <= RX_IDLE;
      rx_cnt     <= '0;
      rx_bit     <= 4'h0;
      rx_len     <= FRAME_LEN_SHORT;
      rx_samp    <= 2'h3;
      rx_shift   <= 9'h000;
      rx_noise   <= 1'b0;
      rx_long    <= 1'b0;
      rx_ps      <= 1'b0;
      idle_bits  <= 4'h0;
      idle_armed <= 1'b0;
    end else if (run) begin
      if (rx_ok) begin
        idle_armed <= 1'b1;
      end else if (idle_evt) begin
        idle_armed <= 1'b0;
      end
      case (rx_state)
        RX_IDLE: begin
          rx_len <= long_word ? FRAME_LEN_LONG : FRAME_LEN_SHORT;
          if (~rx_en | ~rx_level) begin
            rx_cnt    <= '0;
            idle_bits <= 4'h0;
          end else if (rx_cnt == BIT_LAST) begin
            rx_cnt <= '0;
            if (idle_bits != rx_len) begin
              idle_bits <= idle_bits + 4'h1;
            end
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
          // no new frame while powered down
          if (rx_en & ~rx_level) begin
            rx_state <= RX_FRAME;
            rx_bit   <= 4'h0;
            rx_noise <= 1'b0;
            // parity sense held for this byte
            rx_ps    <= ctrl1[CR1_PS];
            rx_long  <= long_word;
          end
        end
        RX_FRAME: begin
          rx_cnt <= (rx_cnt == BIT_LAST) ? '0 : rx_cnt + 1'b1;
          if (rx_cnt == BIT_LAST) begin
            rx_bit <= rx_bit + 4'h1;
          end
          if (rx_cnt == SAMPLE_1) begin
            rx_samp[0] <= rx_level;
          end
          if (rx_cnt == SAMPLE_2) begin
            rx_samp[1] <= rx_level;
          end
          if (rx_eval) begin
            rx_noise <= rx_noise | nz_bit;
            // break shifts in zeros, loads 00h
            if (rx_start_bad | rx_stop) begin
              rx_cnt   <= '0;
              rx_state <= RX_IDLE;
            end else if (rx_bit != 4'h0) begin
              rx_shift <= {maj, rx_shift[8:1]};
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // receive holding register
  // ****************************************
  // held data survives an overrun
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      receive_holding_register <= BYTE_ZERO;
    end else if (rx_ok) begin
      receive_holding_register <= rx_word[7:0];
    end
  end

  // ****************************************
  // read data
  // ****************************************
  assign rd_mux = hit[0] ? status :
                  hit[1] ? receive_holding_register :
                  hit[2] ? ctrl2 : ctrl1;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= BYTE_ZERO;
    end else begin
      RDATA <= (RD & run) ? rd_mux : BYTE_ZERO;
    end
  end

  // ****************************************
  // interrupt request and modes
  // ****************************************
  // or of every flag and enable pair
  wire irq_any = (status[ST_TX_EMPTY] & ctrl2[CR2_TIE])
               | (status[ST_TX_DONE] & ctrl2[CR2_TX_COMPLETE_IRQ_ENABLE])
               | ((status[ST_RX_FULL] | status[ST_OVERRUN] | LIN_SYNC_ERROR_FLAG)
                  & ctrl2[CR2_RIE])
               | (status[ST_IDLE] & ctrl2[CR2_IDLE_IRQ_ENABLE])
               | (status[ST_PARITY] & ctrl1[CR1_PIE] & parity_control_enable)
               | (LIN_HEADER_FLAG & LIN_HEADER_IRQ_ENABLE);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ                      <= 1'b0;
      WAKE_REQ                 <= 1'b0;
      PRESCALER_RUN            <= 1'b0;
      WAKE_ADDRESS_MARK        <= 1'b0;
      LIN_HEADER_DETECT_METHOD <= 1'b0;
    end else begin
      // one request, gated by cpu mask
      IRQ <= irq_any & ~CPU_INT_MASK;
      // wake from wait on any enabled event
      WAKE_REQ <= irq_any & ~CPU_INT_MASK & WAIT_MODE & run;
      PRESCALER_RUN <= run & (~pdn | (tx_state != TX_IDLE) | (rx_state != RX_IDLE));
      // wake bit reused in lin mode
      WAKE_ADDRESS_MARK        <= ctrl1[CR1_WAKE] & ~LIN_ENABLE;
      LIN_HEADER_DETECT_METHOD <= ctrl1[CR1_WAKE] & LIN_ENABLE;
    end
  end

endmodule : usc_top

// ### dv/usc_properties.sv
`timescale 1ns/100ps

// ******************
// port checks
// ******************
module usc_properties (
  // clock and reset
  input wire logic               CLK,
  input wire logic               RST,
  // bus, pins and modes
  input wire logic               RD,
  input wire usc_pkg::usc_byte_t RDATA,
  input wire logic               TXD,
  input wire logic               HALT_MODE,
  input wire logic               WAIT_MODE,
  input wire logic               CPU_INT_MASK,
  input wire logic               LIN_ENABLE,
  input wire logic               LIN_HEADER_FLAG,
  input wire logic               LIN_HEADER_IRQ_ENABLE,
  // requests
  input wire logic               IRQ,
  input wire logic               WAKE_REQ,
  input wire logic               PRESCALER_RUN,
  input wire logic               WAKE_ADDRESS_MARK,
  input wire logic               LIN_HEADER_DETECT_METHOD
);
  import usc_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // request and wake gating, halt freeze, mode selection
  a_irq_masked: assert property ($past(CPU_INT_MASK) |-> !IRQ)
    else $error("irq while masked");
  a_lin_header_irq: assert property (
    $past(LIN_HEADER_FLAG && LIN_HEADER_IRQ_ENABLE && !CPU_INT_MASK) |-> IRQ)
    else $error("header event lost");
  a_wake_needs_wait: assert property (WAKE_REQ |-> $past(WAIT_MODE))
    else $error("wake outside wait");
  a_no_halt_wake: assert property ($past(HALT_MODE) |-> !WAKE_REQ)
    else $error("wake from halt");
  a_halt_stops_clk: assert property ($past(HALT_MODE) |-> !PRESCALER_RUN)
    else $error("prescaler runs in halt");
  a_halt_txd_frozen: assert property (HALT_MODE ##1 HALT_MODE |-> $stable(TXD))
    else $error("txd moved in halt");
  a_halt_read_zero: assert property ($past(RD && HALT_MODE) |-> RDATA == 8'h00)
    else $error("read served in halt");
  a_wake_mark_sel: assert property (WAKE_ADDRESS_MARK |-> !$past(LIN_ENABLE))
    else $error("wake method in lin");
  a_header_method: assert property (LIN_HEADER_DETECT_METHOD |-> $past(LIN_ENABLE))
    else $error("header method off lin");
endmodule : usc_properties

bind usc_top usc_properties i_usc_properties (.CLK, .RST, .RD, .RDATA, .TXD, .HALT_MODE,
  .WAIT_MODE, .CPU_INT_MASK, .LIN_ENABLE, .LIN_HEADER_FLAG, .LIN_HEADER_IRQ_ENABLE, .IRQ,
  .WAKE_REQ, .PRESCALER_RUN, .WAKE_ADDRESS_MARK, .LIN_HEADER_DETECT_METHOD);

// ### dv/usc_remote_node.sv
`timescale 1ns/100ps

// ******************
// remote serial node
// ******************
module usc_remote_node (
  // clock
  input wire logic       clk,
  // line
  input wire logic       txd,
  output logic           rxd,
  output logic     [8:0] got
);
  import usc_pkg::*;
  initial rxd = 1'b1;

  // start, data lsb first, stop; break is all low
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    for (int i = 0; i <= n + 1; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    rxd <= 1'b1; // pulled high when released
  endtask : send

  // capture a frame at mid bit
  task automatic take(input int n);
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      got[i] = txd;
    end
  endtask : take
endmodule : usc_remote_node

// ### dv/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import usc_pkg::*;
  // ******************
  // signals
  // ******************
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, halt = 1'b0, wt = 1'b0;
  logic        mask = 1'b0, lin = 1'b0, lps = 1'b0, lin_parity_select = 1'b0, lhf = 1'b0, lse = 1'b0;
  logic        lin_header_irq_enable = 1'b0, rxd, txd, irq, wake, prun, wam, lin_header_detect_method;
  usc_addr_t   addr = 2'h0;
  usc_byte_t   wdata = 8'h00, rdata, v, d, b;
  logic [31:0] seed = 32'hF2B3;
  logic  [8:0] got;
  int          err_count = 0, comparisons = 0;
  usc_byte_t   rxq[$], txq[$]; // expected received and transmitted bytes

  initial forever #2.5 clk = ~clk;

  usc_top i_usc_top (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RXD(rxd), .TXD(txd), .HALT_MODE(halt), .WAIT_MODE(wt),
    .CPU_INT_MASK(mask), .LIN_ENABLE(lin), .LIN_PARITY_SELECT(lps), .LIN_PARITY_ERROR(lin_parity_select),
    .LIN_HEADER_FLAG(lhf), .LIN_SYNC_ERROR_FLAG(lse), .LIN_HEADER_IRQ_ENABLE(lin_header_irq_enable),
    .IRQ(irq), .WAKE_REQ(wake), .PRESCALER_RUN(prun), .WAKE_ADDRESS_MARK(wam),
    .LIN_HEADER_DETECT_METHOD(lin_header_detect_method));
  usc_remote_node i_node (.clk(clk), .txd(txd), .rxd(rxd), .got(got));

  // ******************
  // helpers
  // ******************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string n, input usc_byte_t e, input usc_byte_t g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wrr(input usc_addr_t a, input usc_byte_t x);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wrr

  task automatic receive_holding_register(input usc_addr_t a, output usc_byte_t x);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    x = rdata;
    @(posedge clk);
  endtask : receive_holding_register

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ******************
  // sequence
  // ******************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wrr(ADDR_STATUS, 8'hFF);
    receive_holding_register(ADDR_STATUS, v);
    chk("status", STATUS_RESET, v);
    wrr(ADDR_CTRL1, 8'h8C);
    receive_holding_register(ADDR_CTRL1, v);
    chk("ctrl1", 8'h0C, v);
    chk("wake mark", 8'h01, {7'h0, wam});
    lin <= 1'b1;
    repeat (2) @(posedge clk);
    chk("method", 8'h01, {7'h0, lin_header_detect_method});
    lin <= 1'b0;
    lhf <= 1'b1;
    lin_header_irq_enable <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    lhf <= 1'b0;
    wrr(ADDR_CTRL1, 8'h04);
    wrr(ADDR_CTRL2, 8'hAC);
    seed = lfsr(seed);
    d = seed[7:0];
    txq.push_back({^d[6:0], d[6:0]});
    seed = lfsr(seed);
    b = {~^seed[6:0], seed[6:0]};
    rxq.push_back(b);
    receive_holding_register(ADDR_STATUS, v);
    fork
      i_node.take(8);
      i_node.send({1'b0, b}, 8, 1'b1);
      begin
        wrr(ADDR_DATA, d);
        repeat (3) @(posedge clk);
        chk("irq", 8'h01, {7'h0, irq});
        mask <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq", 8'h00, {7'h0, irq});
        mask <= 1'b0;
      end
    join
    repeat (16) @(posedge clk);
    chk("tx data", txq.pop_front(), got[7:0]);
    receive_holding_register(ADDR_STATUS, v);
    chk("status", 8'hE1, v);
    receive_holding_register(ADDR_DATA, v);
    chk("rx data", rxq.pop_front(), v);
    receive_holding_register(ADDR_STATUS, v);
    chk("status", 8'hC0, v);
    seed = lfsr(seed);
    b = {^seed[6:0], seed[6:0]};
    rxq.push_back(b);
    i_node.send({1'b0, b}, 8, 1'b1);
    @(posedge clk);
    i_node.send(9'h000, 8, 1'b0);
    repeat (BIT_CYCLES) @(posedge clk);
    receive_holding_register(ADDR_STATUS, v);
    chk("status", 8'hE8, v);
    receive_holding_register(ADDR_DATA, v);
    chk("rx data", rxq.pop_front(), v);
    // break into a free holding register, then a quiet line
    rxq.push_back(8'h00);
    i_node.send(9'h000, 8, 1'b0);
    repeat (11 * BIT_CYCLES) @(posedge clk);
    receive_holding_register(ADDR_STATUS, v);
    chk("status", 8'hF2, v);
    receive_holding_register(ADDR_DATA, v);
    chk("rx data", rxq.pop_front(), v);
    wt <= 1'b1;
    repeat (2) @(posedge clk);
    chk("wake", 8'h01, {7'h0, wake});
    halt <= 1'b1;
    @(posedge clk);
    receive_holding_register(ADDR_STATUS, v);
    chk("halt read", 8'h00, v);
    chk("wake", 8'h00, {7'h0, wake});
    halt <= 1'b0;
    wt <= 1'b0;
    @(posedge clk);
    receive_holding_register(ADDR_STATUS, v);
    chk("status", 8'hC0, v);
    // lin sync error and lin parity error paths
    wrr(ADDR_CTRL2, 8'h2C);
    lse <= 1'b1;
    lps <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    lse <= 1'b0;
    lin_parity_select <= 1'b1;
    @(posedge clk);
    lin_parity_select <= 1'b0;
    receive_holding_register(ADDR_STATUS, v);
    chk("status", 8'hC1, v);
    wrr(ADDR_CTRL1, 8'h05);
    repeat (2) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    wrr(ADDR_CTRL1, 8'h20);
    repeat (2) @(posedge clk);
    chk("prescaler", 8'h00, {7'h0, prun});
    wrap_up();
  end

  // watchdog against a hang, a little beyond the expected run
  initial begin
    repeat (55 * BIT_CYCLES) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule : tb_top
